/* File: pkg/ptc_consts.vh */
// constants for the pwm and cascaded interval timer block
// assumes a single 250 MHz system clock that stands in for the main oscillator
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// ==========================================
// register port
`define PTC_ADDR_W 4
`define PTC_DATA_W 8
`define PTC_OFF_MODE_HIGH 4'h0
`define PTC_OFF_MODE_LOW 4'h1
`define PTC_OFF_CONTROL 4'h2
`define PTC_OFF_COMPARE_HIGH 4'h3
`define PTC_OFF_PERIOD 4'h4
`define PTC_OFF_HIGH_PHASE 4'h5
`define PTC_OFF_COUNT_LOW 4'h6
`define PTC_OFF_COUNT_HIGH 4'h7
`define PTC_OFF_STATUS 4'h8
`define PTC_OFF_CH1_CONTROL 4'h9

// ==========================================
// reset values and byte constants
`define PTC_RESET_BYTE 8'h00
`define PTC_COUNT_ZERO 8'h00
`define PTC_COUNT_FULL 8'hff
`define PTC_COUNT_ONE 8'h01

// ==========================================
// mode register fields
`define PTC_MODE_MASK 8'h7f
`define PTC_CP_MSB 6
`define PTC_CP_LSB 4
`define PTC_START_BIT 3
`define PTC_RUN_BIT 2
`define PTC_SEL_MSB 1
`define PTC_SEL_LSB 0
`define PTC_SEL_PWM 2'h1
`define PTC_SEL_16BIT 2'h2

// ==========================================
// count pulse select codes
`define PTC_CP_EXT_RISE 3'h0
`define PTC_CP_EXT_FALL 3'h1
`define PTC_CP_CODE2 3'h2
`define PTC_CP_CODE3 3'h3
`define PTC_CP_CODE4 3'h4
`define PTC_CP_CODE5 3'h5
`define PTC_CP_CODE6 3'h6
`define PTC_CP_CODE7 3'h7
// prescaler tap numbers: tap k pulses at main_osc_freq / 2^k
`define PTC_TAPS 12
`define PTC_TAP_FX 0
`define PTC_TAP_D1 1
`define PTC_TAP_D4 4
`define PTC_TAP_D5 5
`define PTC_TAP_D6 6
`define PTC_TAP_D8 8
`define PTC_TAP_D10 10
`define PTC_TAP_D12 12

// ==========================================
// control registers and status
`define PTC_CTRL_MASK 8'h8f
`define PTC_GATE_BIT 7
`define PTC_OE_B_BIT 3
`define PTC_CH1_MASK 8'h08
`define PTC_OE_A_BIT 3
`define PTC_ST_IRQ_BIT 0
`define PTC_ST_TOGGLE_BIT 1
`define PTC_ST_PHASE_BIT 2

`endif

/* File: design/ptc_sync.v */
// two-flop synchroniser for a group of asynchronous level inputs
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/1ps
`default_nettype none

module ptc_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: design/ptc_prescaler.v */
// free-running prescaler giving one-cycle enables at clk / 2^k
// assumes clk_i is the main oscillator; tap 0 is high every cycle
`timescale 1ns/1ps
`default_nettype none

module ptc_prescaler #(
  parameter TAPS = 12
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // tap k pulses once every 2^k cycles
  output wire [TAPS:0] tick_o
);

  reg [TAPS-1:0] div;

  // never restarted, so divided taps keep a fixed phase to each other
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div <= {TAPS{1'b0}};
    end else begin
      div <= div + {{(TAPS-1){1'b0}}, 1'b1};
    end
  end

  assign tick_o[0] = 1'b1;

  // each tap fires when its low bits are all ones
  genvar k;
  generate
    for (k = 1; k <= TAPS; k = k + 1) begin : g_tap
      assign tick_o[k] = &div[k-1:0];
    end
  endgenerate

endmodule

`default_nettype wire

/* File: design/ptc_top.v */
// pwm generator and cascaded 16-bit interval timer / event counter
// assumes a register master on the same clock and external pins that are
// asynchronous; sampling signal comes from another timer's output
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"

module ptc_top (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // register port
  input wire [`PTC_ADDR_W-1:0] addr_i,
  input wire [`PTC_DATA_W-1:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`PTC_DATA_W-1:0] rd_data_o,
  // external count inputs and sampling gate
  input wire ext_count_in_a_i,
  input wire ext_count_in_b_i,
  input wire sample_gate_i,
  // pulse output and flag
  output reg pulse_out_pin_o,
  output reg timer_irq_flag_o
);

  // ==========================================
  // registers
  reg [7:0] mode_reg_high;
  reg [7:0] mode_reg_low;
  reg [7:0] timer_control;
  reg [7:0] ch1_control;
  reg [7:0] compare_high;
  reg [7:0] period_compare;
  reg [7:0] high_phase_compare;
  reg [7:0] count_low;
  reg [7:0] count_high;
  reg output_toggle;
  reg low_phase;
  reg [2:0] pin_prev;

  wire [`PTC_TAPS:0] tap;
  wire [2:0] pin_s;

  // ==========================================
  // helpers
  // mode field of a mode register
  function [1:0] mode_sel;
    input [7:0] mreg;
    begin
      mode_sel = mreg[`PTC_SEL_MSB:`PTC_SEL_LSB];
    end
  endfunction

  // count pulse field of a mode register
  function [2:0] cp_sel;
    input [7:0] mreg;
    begin
      cp_sel = mreg[`PTC_CP_MSB:`PTC_CP_LSB];
    end
  endfunction

  // ==========================================
  // prescaler and pin synchronisers
  ptc_prescaler #(
    .TAPS(`PTC_TAPS)
  ) u_prescaler (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(tap)
  );

  ptc_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({sample_gate_i, ext_count_in_b_i, ext_count_in_a_i}),
    .sync_o(pin_s)
  );

  // delayed copy of the synchronised pins for edge detection
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_prev <= 3'h0;
    end else begin
      pin_prev <= pin_s;
    end
  end

  wire rise_a = pin_s[0] & ~pin_prev[0];
  wire fall_a = ~pin_s[0] & pin_prev[0];
  wire rise_b = pin_s[1] & ~pin_prev[1];
  wire fall_b = ~pin_s[1] & pin_prev[1];
  wire gate_level = pin_s[2];

  // ==========================================
  // mode decode
  wire pwm_mode = (mode_sel(mode_reg_low) == `PTC_SEL_PWM);
  wire wide_mode = (mode_sel(mode_reg_low) == `PTC_SEL_16BIT) &&
                   (mode_sel(mode_reg_high) == `PTC_SEL_16BIT);
  wire run_low = mode_reg_low[`PTC_RUN_BIT];
  // gate halts counting while the sampling signal is low
  wire gate_ok = ~timer_control[`PTC_GATE_BIT] | gate_level;
  wire count_on = run_low & gate_ok;

  // ==========================================
  // channel-2 count pulse select
  reg cp_low;
  always @* begin
    case (cp_sel(mode_reg_low))
      `PTC_CP_EXT_RISE: cp_low = rise_b;
      `PTC_CP_EXT_FALL: cp_low = fall_b;
      `PTC_CP_CODE2: cp_low = tap[`PTC_TAP_D1];
      `PTC_CP_CODE3: cp_low = tap[`PTC_TAP_FX];
      `PTC_CP_CODE4: cp_low = tap[`PTC_TAP_D10];
      `PTC_CP_CODE5: cp_low = tap[`PTC_TAP_D8];
      `PTC_CP_CODE6: cp_low = tap[`PTC_TAP_D6];
      default: cp_low = tap[`PTC_TAP_D4];
    endcase
  end

  wire tick_low = cp_low & count_on;

  // 16-bit match needs both halves equal at once
  wire match_low = (count_low == period_compare);
  wire match_wide = match_low && (count_high == compare_high);
  wire wrap_low = (count_low == `PTC_COUNT_FULL);
  // overflow only when the low byte really rolls over
  wire ovf_low = tick_low & wide_mode & ~match_wide & wrap_low;

  // ==========================================
  // channel-1 count pulse select
  reg cp_high;
  always @* begin
    case (cp_sel(mode_reg_high))
      `PTC_CP_EXT_RISE: cp_high = rise_a;
      `PTC_CP_EXT_FALL: cp_high = fall_a;
      `PTC_CP_CODE2: cp_high = ovf_low;
      `PTC_CP_CODE3: cp_high = tap[`PTC_TAP_D5];
      `PTC_CP_CODE4: cp_high = tap[`PTC_TAP_D12];
      `PTC_CP_CODE5: cp_high = tap[`PTC_TAP_D10];
      `PTC_CP_CODE6: cp_high = tap[`PTC_TAP_D8];
      default: cp_high = tap[`PTC_TAP_D6];
    endcase
  end

  // the high byte only moves in 16-bit mode; other mode codes stop its count
  wire tick_high = wide_mode & count_on & cp_high & ~(tick_low & match_wide);

  // ==========================================
  // register port decode
  wire wr_mode_high = wr_i && (addr_i == `PTC_OFF_MODE_HIGH);
  wire wr_mode_low = wr_i && (addr_i == `PTC_OFF_MODE_LOW);
  wire wr_status = wr_i && (addr_i == `PTC_OFF_STATUS);
  // start requests: writing one to bit 3
  wire start_low = wr_mode_low & wr_data_i[`PTC_START_BIT];
  wire start_high = wr_mode_high & wr_data_i[`PTC_START_BIT];

  // pwm events, compared against the value of the current phase
  wire pwm_cmp = low_phase ? match_low : (count_low == high_phase_compare);
  wire pwm_hit = tick_low & pwm_mode & pwm_cmp;
  wire wide_hit = tick_low & wide_mode & match_wide;
  // only the period match and the 16-bit match raise the flag
  wire irq_set = (pwm_hit & low_phase) | wide_hit;

  // ==========================================
  // mode, control and compare registers
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_reg_high <= `PTC_RESET_BYTE;
      mode_reg_low <= `PTC_RESET_BYTE;
      timer_control <= `PTC_RESET_BYTE;
      ch1_control <= `PTC_RESET_BYTE;
      compare_high <= `PTC_RESET_BYTE;
      period_compare <= `PTC_RESET_BYTE;
      high_phase_compare <= `PTC_RESET_BYTE;
    end else begin
      // start bit lives one cycle, the timer has started by then
      mode_reg_high[`PTC_START_BIT] <= 1'b0;
      mode_reg_low[`PTC_START_BIT] <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          `PTC_OFF_MODE_HIGH: mode_reg_high <= wr_data_i & `PTC_MODE_MASK;
          `PTC_OFF_MODE_LOW: mode_reg_low <= wr_data_i & `PTC_MODE_MASK;
          `PTC_OFF_CONTROL: timer_control <= wr_data_i & `PTC_CTRL_MASK;
          `PTC_OFF_CH1_CONTROL: ch1_control <= wr_data_i & `PTC_CH1_MASK;
          `PTC_OFF_COMPARE_HIGH: compare_high <= wr_data_i;
          `PTC_OFF_PERIOD: period_compare <= wr_data_i;
          `PTC_OFF_HIGH_PHASE: high_phase_compare <= wr_data_i;
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // low counter: pwm phases and low byte of the 16-bit count
  // zero compares are not guarded; software must avoid them
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_low <= `PTC_COUNT_ZERO;
      low_phase <= 1'b0;
    end else if (start_low) begin
      count_low <= `PTC_COUNT_ZERO;
      low_phase <= 1'b0;
    end else if (pwm_hit) begin
      count_low <= `PTC_COUNT_ZERO;
      low_phase <= ~low_phase;
    end else if (wide_hit) begin
      count_low <= `PTC_COUNT_ZERO;
    end else if (tick_low && (pwm_mode || wide_mode)) begin
      count_low <= count_low + `PTC_COUNT_ONE;
    end
  end

  // ==========================================
  // high counter: channel-1 byte of the cascade
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_high <= `PTC_COUNT_ZERO;
    end else if (start_high || start_low) begin
      // a channel-2 start restarts the whole 16-bit count
      count_high <= `PTC_COUNT_ZERO;
    end else if (wide_hit) begin
      count_high <= `PTC_COUNT_ZERO;
    end else if (tick_high) begin
      count_high <= count_high + `PTC_COUNT_ONE;
    end
  end

  // ==========================================
  // output toggle flip-flop
  // pwm start loads the high level so the first phase is the high one
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      output_toggle <= 1'b0;
    end else if (start_low) begin
      output_toggle <= (mode_sel(wr_data_i) == `PTC_SEL_PWM);
    end else if (pwm_hit || wide_hit) begin
      output_toggle <= ~output_toggle;
    end
  end

  // ==========================================
  // interrupt request flag: set beats any clear in the same cycle
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_irq_flag_o <= 1'b0;
    end else if (irq_set) begin
      timer_irq_flag_o <= 1'b1;
    end else if (start_low) begin
      timer_irq_flag_o <= 1'b0;
    end else if (wr_status && wr_data_i[`PTC_ST_IRQ_BIT]) begin
      timer_irq_flag_o <= 1'b0;
    end
  end

  // ==========================================
  // pulse output pin, registered so it is glitch free
  // 16-bit mode takes the channel-1 enable instead of channel 2
  wire pin_enable = wide_mode ? ch1_control[`PTC_OE_A_BIT]
                              : timer_control[`PTC_OE_B_BIT];
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pulse_out_pin_o <= 1'b0;
    end else begin
      pulse_out_pin_o <= pin_enable & output_toggle;
    end
  end

  // ==========================================
  // read port: data only in the cycle after the strobe
  reg [7:0] rd_mux;
  always @* begin
    case (addr_i)
      `PTC_OFF_MODE_HIGH: rd_mux = mode_reg_high;
      `PTC_OFF_MODE_LOW: rd_mux = mode_reg_low;
      `PTC_OFF_CONTROL: rd_mux = timer_control;
      `PTC_OFF_CH1_CONTROL: rd_mux = ch1_control;
      `PTC_OFF_COMPARE_HIGH: rd_mux = compare_high;
      `PTC_OFF_PERIOD: rd_mux = period_compare;
      `PTC_OFF_HIGH_PHASE: rd_mux = high_phase_compare;
      `PTC_OFF_COUNT_LOW: rd_mux = count_low;
      `PTC_OFF_COUNT_HIGH: rd_mux = count_high;
      `PTC_OFF_STATUS: rd_mux = {5'h00, low_phase, output_toggle, timer_irq_flag_o};
      default: rd_mux = `PTC_RESET_BYTE;
    endcase
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= `PTC_RESET_BYTE;
    end else if (rd_i) begin
      rd_data_o <= rd_mux;
    end else begin
      rd_data_o <= `PTC_RESET_BYTE;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/ptc_top_checker.sv */
// checker for the timer's register port, pulse pin and flag
// assumes it sees only the top module's ports, bound from the bench
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"
module ptc_top_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [`PTC_ADDR_W-1:0] addr_i,
  input wire logic [`PTC_DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [`PTC_DATA_W-1:0] rd_data_o,
  // pin and flag
  input wire logic pulse_out_pin_o,
  input wire logic timer_irq_flag_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ==========================================
  // shadow registers; start bit left out since it clears itself
  logic [7:0] mh_q, ml_q, ctl_q, ch1_q, exp_q;
  logic wr_mode_q;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mh_q <= 8'h00;
      ml_q <= 8'h00;
      ctl_q <= 8'h00;
      ch1_q <= 8'h00;
      exp_q <= 8'h00;
      wr_mode_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == `PTC_OFF_MODE_HIGH) mh_q <= wr_data_i & 8'h77;
      if (wr_i && addr_i == `PTC_OFF_MODE_LOW) ml_q <= wr_data_i & 8'h77;
      if (wr_i && addr_i == `PTC_OFF_CONTROL) ctl_q <= wr_data_i & `PTC_CTRL_MASK;
      if (wr_i && addr_i == `PTC_OFF_CH1_CONTROL) ch1_q <= wr_data_i & `PTC_CH1_MASK;
      wr_mode_q <= wr_i && addr_i < 4'h2;
      case (addr_i)
        `PTC_OFF_MODE_HIGH: exp_q <= mh_q;
        `PTC_OFF_MODE_LOW: exp_q <= ml_q;
        `PTC_OFF_CONTROL: exp_q <= ctl_q;
        `PTC_OFF_CH1_CONTROL: exp_q <= ch1_q;
        default: exp_q <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // assertions
  a_read_idle: assert property (!rd_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside an answer");
  a_unmapped_read: assert property (rd_i && addr_i > 4'h9 |=> rd_data_o == 8'h00)
    else $error("unmapped read returned data");
  a_mode_read: assert property (
    rd_i && addr_i < 4'h2 |=> (rd_data_o & 8'hf7) == exp_q)
    else $error("mode register read differs");
  a_start_clears: assert property (
    rd_i && addr_i < 4'h2 && !wr_mode_q |=> !rd_data_o[3])
    else $error("start bit still set");
  a_ctrl_read: assert property (
    rd_i && (addr_i == 4'h2 || addr_i == 4'h9) |=> rd_data_o == exp_q)
    else $error("control read differs");
  a_pin_off: assert property (!ctl_q[3] && !ch1_q[3] |=> !pulse_out_pin_o)
    else $error("pin high while disabled");
  a_wide_enable: assert property (
    mh_q[1:0] == 2'h2 && ml_q[1:0] == 2'h2 && !ch1_q[3] |=> !pulse_out_pin_o)
    else $error("wide mode pin ignores its own enable");
  a_start_flag_clear: assert property (
    wr_i && addr_i == 4'h1 && wr_data_i[3] && !wr_data_i[2] && !ml_q[2]
    |=> !timer_irq_flag_o)
    else $error("start left the flag set");
  a_flag_sticky: assert property (
    timer_irq_flag_o && !(wr_i && (addr_i == 4'h1 || addr_i == 4'h8)) |=> timer_irq_flag_o)
    else $error("flag dropped by itself");
endmodule
`default_nettype wire

/* File: testbench/ptc_pulse_load.sv */
// load on the pulse pin: measures how long each level lasts
// assumes the pin is a clean registered level on clk_i
`timescale 1ns/1ps
`default_nettype none
module ptc_pulse_load (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pin from the timer
  input wire logic pin_i,
  // last widths in cycles and number of level changes
  output logic [15:0] high_len_o,
  output logic [15:0] low_len_o,
  output logic [15:0] edges_o
);
  logic [15:0] run_len;
  logic pin_q;
  // a change latches the width of the level that just ended
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_len <= 16'h0000;
      pin_q <= 1'b0;
      high_len_o <= 16'h0000;
      low_len_o <= 16'h0000;
      edges_o <= 16'h0000;
    end else begin
      pin_q <= pin_i;
      if (pin_i != pin_q) begin
        run_len <= 16'h0001;
        edges_o <= edges_o + 16'h0001;
        if (pin_q) high_len_o <= run_len;
        else low_len_o <= run_len;
      end else begin
        run_len <= run_len + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pwm_and_cascaded_interval_timer_test.sv */
// self-checking bench for the pwm and cascaded interval timer
// assumes the pulse load model and the checker beside the design
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"
module pwm_and_cascaded_interval_timer_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_a = 1'b0;
  logic ext_b = 1'b0;
  logic gate = 1'b0;
  wire [7:0] rdat;
  wire pin;
  wire flag;
  wire [15:0] hi_len, lo_len, edges;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] m, n, v, c1, c2;
  int tap [8] = '{0, 0, 1, 0, 10, 8, 6, 4};

  always #2 clk_i = ~clk_i;

  ptc_top i_ptc_top (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wr_data_i(wdat),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .ext_count_in_a_i(ext_a),
    .ext_count_in_b_i(ext_b), .sample_gate_i(gate), .pulse_out_pin_o(pin),
    .timer_irq_flag_o(flag));
  ptc_pulse_load i_ptc_pulse_load (.clk_i(clk_i), .reset_i(reset_i), .pin_i(pin),
    .high_len_o(hi_len), .low_len_o(lo_len), .edges_o(edges));

  // ==========================================
  // bus tasks; one idle cycle after each strobe keeps drivers clean
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // range compare; an unknown never lands inside the range
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      $display("MISMATCH at %0t got %h expected %h..%h", $time, got, lo, hi);
      miscompares++;
    end
  endtask
  // phase or interval length in count pulses for a compare value
  function automatic int phase_len(input int cmp);
    return cmp + 1;
  endfunction
  task automatic wait_edges(input int k);
    int base;
    base = edges;
    for (int i = 0; i < 4000 && edges < base + k; i++) @(posedge clk_i);
  endtask
  task automatic final_report;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog: the tests need about 15k cycles, allow four times that
  initial begin
    #240000;
    miscompares++;
    final_report();
  end

  // ==========================================
  // main sequence
  initial begin
    v = 8'($urandom(64));
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd_reg(4'(a), v);
      chk(v, 0, 0);
    end
    repeat (3) begin
      v = 8'($urandom);
      wr_reg(`PTC_OFF_CONTROL, v);
      rd_reg(`PTC_OFF_CONTROL, c1);
      chk(c1, v & 8'h8f, v & 8'h8f);
    end
    // pwm with random short phases
    m = 8'($urandom_range(6, 1));
    n = 8'($urandom_range(6, 1));
    wr_reg(`PTC_OFF_HIGH_PHASE, m);
    wr_reg(`PTC_OFF_PERIOD, n);
    wr_reg(`PTC_OFF_CONTROL, 8'h08);
    wr_reg(`PTC_OFF_MODE_LOW, 8'h3d);
    rd_reg(`PTC_OFF_MODE_LOW, c1);
    chk(c1, 8'h35, 8'h35);
    wait_edges(6);
    chk(hi_len, phase_len(m), phase_len(m));
    chk(lo_len, phase_len(n), phase_len(n));
    chk(flag, 1, 1);
    // stop holds the count, start without run clears count and flag
    wr_reg(`PTC_OFF_MODE_LOW, 8'h31);
    rd_reg(`PTC_OFF_COUNT_LOW, c1);
    repeat (20) @(posedge clk_i);
    rd_reg(`PTC_OFF_COUNT_LOW, c2);
    chk(c2, c1, c1);
    wr_reg(`PTC_OFF_MODE_LOW, 8'h39);
    rd_reg(`PTC_OFF_COUNT_LOW, c2);
    chk({c2, 7'h0, flag}, 0, 0);
    // running pwm with the enable off keeps the pin low
    wr_reg(`PTC_OFF_MODE_LOW, 8'h3d);
    wr_reg(`PTC_OFF_CONTROL, 8'h00);
    repeat (2) @(posedge clk_i);
    v = 8'h00;
    repeat (40) @(posedge clk_i) v = v | pin;
    chk(v, 0, 0);
    // gate control: low gate freezes, high gate counts
    wr_reg(`PTC_OFF_PERIOD, 8'hff);
    wr_reg(`PTC_OFF_HIGH_PHASE, 8'hff);
    wr_reg(`PTC_OFF_CONTROL, 8'h88);
    wr_reg(`PTC_OFF_MODE_LOW, 8'h3d);
    rd_reg(`PTC_OFF_COUNT_LOW, c1);
    repeat (10) @(posedge clk_i);
    rd_reg(`PTC_OFF_COUNT_LOW, c2);
    chk(c2, c1, c1);
    @(posedge clk_i) gate <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd_reg(`PTC_OFF_COUNT_LOW, c2);
    chk(c2, c1 + 17, c1 + 22);
    // every count pulse code; the free prescaler allows one tick of slack
    wr_reg(`PTC_OFF_CONTROL, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr_reg(`PTC_OFF_MODE_LOW, {1'b0, 3'(k), 4'hd});
      if (k < 2) begin
        repeat (5) begin
          repeat (4) @(posedge clk_i);
          ext_b <= ~ext_b;
          repeat (4) @(posedge clk_i);
          ext_b <= ~ext_b;
        end
        repeat (4) @(posedge clk_i);
      end else begin
        repeat (8 << tap[k]) @(posedge clk_i);
      end
      rd_reg(`PTC_OFF_COUNT_LOW, c1);
      chk(c1, k < 2 ? 5 : 7, k < 2 ? 5 : 9);
    end
    // cascaded 16-bit interval, pin on the channel-1 enable only
    v = 8'($urandom_range(8, 1));
    wr_reg(`PTC_OFF_COMPARE_HIGH, 8'h01);
    wr_reg(`PTC_OFF_PERIOD, v);
    wr_reg(`PTC_OFF_MODE_HIGH, 8'h22);
    wr_reg(`PTC_OFF_MODE_LOW, 8'h3e);
    wr_reg(`PTC_OFF_CONTROL, 8'h08);
    c1 = 8'h00;
    repeat (600) @(posedge clk_i) c1 = c1 | pin;
    chk(c1, 0, 0);
    wr_reg(`PTC_OFF_CH1_CONTROL, 8'h08);
    wait_edges(4);
    chk(hi_len, phase_len(256 + v), phase_len(256 + v));
    chk(lo_len, phase_len(256 + v), phase_len(256 + v));
    chk(flag, 1, 1);
    // stopped timer: a status write of one clears the flag
    wr_reg(`PTC_OFF_MODE_LOW, 8'h32);
    wr_reg(`PTC_OFF_STATUS, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(flag, 0, 0);
    // channel-1 pin rising edges feed the high byte; compare kept out of reach
    wr_reg(`PTC_OFF_COMPARE_HIGH, 8'hff);
    wr_reg(`PTC_OFF_MODE_HIGH, 8'h02);
    wr_reg(`PTC_OFF_MODE_LOW, 8'h3e);
    repeat (3) begin
      repeat (4) @(posedge clk_i);
      ext_a <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_a <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    rd_reg(`PTC_OFF_COUNT_HIGH, c1);
    chk(c1, 3, 3);
    final_report();
  end
endmodule

bind ptc_top ptc_top_checker i_ptc_top_checker (.clk_i(clk_i), .reset_i(reset_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .pulse_out_pin_o(pulse_out_pin_o), .timer_irq_flag_o(timer_irq_flag_o));
`default_nettype wire
